// ==== gpc_phy_if.sv ====
// Gigabit PHY-side interface: transmit pad registers, forwarded clock, rx capture.
// Assumes one 125 MHz reference; the rx clock arrives as a pin and is sampled.
//
// Function
// - Transmit logic and user transmit stream run on one 125 MHz reference.
// - GMII transmit data and control leave through output pad flip-flops.
// - Forwarded transmit clock comes from a DDR register like the data.
// - GMII forwarded clock is the inverted reference, rising mid data window.
// - Collision and carrier sense are asynchronous and synchronised before use.
// - System clock times all receive logic and the user receive side; the PHY rx clock is sampled.
// - Receive pins sampled in input flops with an adjustable delay tap.
// - RGMII transmit data and control use DDR registers on both edges.
// - With an output delay, RGMII clock gets 2 ns after its DDR register.
// - Without one, a 90 degree reference clocks only the RGMII clock register.
// - Transmit references may be shared; each instance uses its own rx clock.
// - RGMII halves the pin count by DDR on data and control.
`timescale 1ns/1ns
`default_nettype none
module gpc_phy_if
   import gpc_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_b_in,
   input  wire logic                 ce_in,
   input  wire logic                 cfg_rgmii_in,
   input  wire logic                 cfg_out_delay_in,
   input  wire logic                 cfg_half_duplex_in,
   input  wire logic [RX_TAP_W-1:0]  rx_tap_sel_in,
   input  wire gpc_byte_t            tx_byte_in,
   input  wire logic                 tx_valid_in,
   output logic                      tx_ready_out,
   output gpc_tx_pins_t              tx_pins_out,
   input  wire logic                 phy_col_in,
   input  wire logic                 phy_crs_in,
   input  wire logic                 phy_rx_clk_in,
   input  wire gpc_rx_sample_t       phy_rx_in,
   output gpc_byte_t                 rx_byte_out,
   output logic                      rx_valid_out,
   output logic                      col_out,
   output logic                      crs_out
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_pipe_r;
   logic       rst_sync_b;

   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rst_pipe_r <= 2'h0;
      end
      else
      begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_r[1];

   // ----------------------------------------
   // Transmit buffer
   // ----------------------------------------
   gpc_top_st_t    st_r;
   gpc_top_st_t    st_nxt;
   gpc_byte_t      buf_data;
   logic           buf_valid;
   logic           drain_rdy;
   logic           tx_take;
   logic           rx_rise;
   logic           rx_fall;
   gpc_rx_sample_t rx_pick;

   // Half duplex defers while the line is busy; the buffer absorbs the stall
   assign drain_rdy = !(cfg_half_duplex_in && st_r.crs_lvl);
   assign tx_take   = ce_in && buf_valid && drain_rdy;

   gpc_buf gpc_buf_inst (
      .sys_clk_in    (sys_clk_in),
      .rst_b_in      (rst_sync_b),
      .ce_in         (ce_in),
      .in_valid_in   (tx_valid_in),
      .in_ready_out  (tx_ready_out),
      .in_data_in    (tx_byte_in),
      .out_valid_out (buf_valid),
      .out_ready_in  (drain_rdy),
      .out_data_out  (buf_data)
   );

   // ----------------------------------------
   // Receive clock edges
   // ----------------------------------------
   // The rx clock is sampled, so it must run well below the system clock here
   assign rx_rise = (st_r.rxc_sync[1] == st_r.rxc_sync[2]) && st_r.rxc_sync[2]
                    && !st_r.rxc_lvl;
   assign rx_fall = (st_r.rxc_sync[1] == st_r.rxc_sync[2]) && !st_r.rxc_sync[2]
                    && st_r.rxc_lvl;
   assign rx_pick = st_r.rx_tap[rx_tap_sel_in];

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rx_valid = 1'b0;
      // Pin inputs: three stages, a change counts once stages two and three agree
      st_nxt.col_sync = {st_r.col_sync[1:0], phy_col_in};
      st_nxt.crs_sync = {st_r.crs_sync[1:0], phy_crs_in};
      st_nxt.rxc_sync = {st_r.rxc_sync[1:0], phy_rx_clk_in};
      st_nxt.rx_sync  = {st_r.rx_sync[1:0], phy_rx_in};
      if (st_r.col_sync[1] == st_r.col_sync[2])
      begin
         st_nxt.col_lvl = st_r.col_sync[2];
      end
      if (st_r.crs_sync[1] == st_r.crs_sync[2])
      begin
         st_nxt.crs_lvl = st_r.crs_sync[2];
      end
      if (st_r.rxc_sync[1] == st_r.rxc_sync[2])
      begin
         st_nxt.rxc_lvl = st_r.rxc_sync[2];
      end
      // Delay line gives the adjustable sampling point
      st_nxt.rx_tap = {st_r.rx_tap[RX_TAPS-2:0], st_r.rx_sync[2]};

      // Transmit pad registers, one byte per reference period
      st_nxt.tx_pins = '0;
      if (cfg_rgmii_in)
      begin
         if (tx_take)
         begin
            st_nxt.tx_pins.d_rise  = {NIB_ZERO, buf_data.data[3:0]};
            st_nxt.tx_pins.d_fall  = {NIB_ZERO, buf_data.data[7:4]};
            st_nxt.tx_pins.en_rise = 1'b1;
            st_nxt.tx_pins.en_fall = !buf_data.err;
         end
         st_nxt.tx_pins.clk_rise  = 1'b1;
         st_nxt.tx_pins.clk_fall  = 1'b0;
         st_nxt.tx_pins.clk_delay = cfg_out_delay_in;
         st_nxt.tx_pins.clk_quad  = !cfg_out_delay_in;
      end
      else
      begin
         if (tx_take)
         begin
            st_nxt.tx_pins.d_rise  = buf_data.data;
            st_nxt.tx_pins.d_fall  = buf_data.data;
            st_nxt.tx_pins.en_rise = 1'b1;
            st_nxt.tx_pins.en_fall = 1'b1;
            st_nxt.tx_pins.er_rise = buf_data.err;
            st_nxt.tx_pins.er_fall = buf_data.err;
         end
         st_nxt.tx_pins.clk_rise = 1'b0;
         st_nxt.tx_pins.clk_fall = 1'b1;
      end

      // Receive capture
      if (rx_rise)
      begin
         if (cfg_rgmii_in)
         begin
            st_nxt.lo_nib = rx_pick.d[3:0];
            st_nxt.lo_dv  = rx_pick.dv;
            st_nxt.phase  = RX_HIGH;
         end
         else
         begin
            st_nxt.rx_byte  = '{data: rx_pick.d, err: rx_pick.er};
            st_nxt.rx_valid = rx_pick.dv;
         end
      end
      else if (rx_fall && cfg_rgmii_in)
      begin
         case (st_r.phase)
            RX_HIGH:
            begin
               // Falling edge carries valid xor error on the control line
               st_nxt.rx_byte  = '{data: {rx_pick.d[3:0], st_r.lo_nib},
                                   err: st_r.lo_dv ^ rx_pick.dv};
               st_nxt.rx_valid = st_r.lo_dv;
               st_nxt.phase    = RX_LOW;
            end
            RX_LOW:
            begin
               st_nxt.phase = RX_LOW;
            end
            default:
            begin
               st_nxt.phase = RX_LOW;
            end
         endcase
      end
   end

   // Clock enable low freezes every register but the reset release
   always_ff @(posedge sys_clk_in or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         st_r       <= '0;
         st_r.phase <= RX_LOW;
      end
      else if (ce_in)
      begin
         st_r <= st_nxt;
      end
   end

   assign tx_pins_out  = st_r.tx_pins;
   assign rx_byte_out  = st_r.rx_byte;
   assign rx_valid_out = st_r.rx_valid;
   assign col_out      = st_r.col_lvl;
   assign crs_out      = st_r.crs_lvl;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_sync_b);

   sequence s_col_steady;
      (ce_in && phy_col_in) [*4];
   endsequence
   sequence s_rgmii_high_fall;
      ce_in && cfg_rgmii_in && rx_fall && (st_r.phase == RX_HIGH);
   endsequence

   // Release edge still loads reset pins, so skip attempts that start on it
   a_gmii_clk_inverse: assert property (
      $past(rst_sync_b) && ce_in && !cfg_rgmii_in |=> !tx_pins_out.clk_rise
      && tx_pins_out.clk_fall)
      else $error("gmii forwarded clock not inverted");
   a_rgmii_clk_delay: assert property (
      $past(rst_sync_b) && ce_in && cfg_rgmii_in && cfg_out_delay_in
      |=> tx_pins_out.clk_delay && !tx_pins_out.clk_quad)
      else $error("rgmii clock delay not selected");
   a_rgmii_clk_quad: assert property (
      $past(rst_sync_b) && ce_in && cfg_rgmii_in && !cfg_out_delay_in
      |=> tx_pins_out.clk_quad && !tx_pins_out.clk_delay)
      else $error("rgmii clock not on quadrature reference");
   a_gmii_tx_byte: assert property (
      tx_take && !cfg_rgmii_in |=> tx_pins_out.en_rise
      && tx_pins_out.d_rise == $past(buf_data.data)
      && tx_pins_out.er_rise == $past(buf_data.err))
      else $error("gmii byte not registered to pads");
   a_rgmii_tx_nibbles: assert property (
      tx_take && cfg_rgmii_in |=> tx_pins_out.d_rise[3:0] == $past(buf_data.data[3:0])
      && tx_pins_out.d_fall[3:0] == $past(buf_data.data[7:4]))
      else $error("rgmii nibble order wrong");
   a_col_sync_steady: assert property (s_col_steady |=> col_out)
      else $error("collision not seen after sync");
   a_crs_defer_tx: assert property (
      cfg_half_duplex_in && crs_out |-> !tx_take)
      else $error("transmit while carrier sensed");
   a_gmii_rx_byte: assert property (
      ce_in && !cfg_rgmii_in && rx_rise |=> rx_valid_out == $past(rx_pick.dv)
      && rx_byte_out.data == $past(rx_pick.d))
      else $error("gmii rx byte not captured");
   a_rgmii_rx_pair: assert property (
      s_rgmii_high_fall |=> rx_byte_out.data[3:0] == $past(st_r.lo_nib)
      && rx_valid_out == $past(st_r.lo_dv))
      else $error("rgmii nibbles not paired");

endmodule
`default_nettype wire

// ==== gpc_pkg.sv ====
// Shared constants and carrier types for the gigabit PHY-side interface block.
// Assumes a single 125 MHz system clock drives every user of these types.
package gpc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_FREQ_MHZ    = 125;
   localparam int CLK_PERIOD_NS   = 8;
   localparam int TX_CLK_SKEW_NS  = 2;
   // Skew as a phase of the reference: 2 ns of 8 ns is a quarter turn
   localparam int TX_CLK_SKEW_DEG = TX_CLK_SKEW_NS * 360 / CLK_PERIOD_NS;

   // ----------------------------------------
   // Widths and depths
   // ----------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam int RX_TAPS     = 8;
   localparam int RX_TAP_W    = 3;
   localparam int BUF_DEPTH   = 2;
   localparam logic [1:0] BUF_FULL  = 2'h2;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE   = 2'h1;
   localparam logic [3:0] NIB_ZERO  = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] data;
      logic       err;
   } gpc_byte_t;

   // Each DDR pin is a rise/fall pair; the pad register joins them
   typedef struct packed {
      logic [7:0] d_rise;
      logic [7:0] d_fall;
      logic       en_rise;
      logic       en_fall;
      logic       er_rise;
      logic       er_fall;
      logic       clk_rise;
      logic       clk_fall;
      logic       clk_delay;
      logic       clk_quad;
   } gpc_tx_pins_t;

   typedef struct packed {
      logic [7:0] d;
      logic       dv;
      logic       er;
   } gpc_rx_sample_t;

   typedef enum logic [1:0] {
      RX_LOW  = 2'b01,
      RX_HIGH = 2'b10
   } gpc_rx_phase_t;

   typedef struct packed {
      gpc_byte_t [BUF_DEPTH-1:0] mem;
      logic                      wp;
      logic                      rp;
      logic [1:0]                cnt;
   } gpc_buf_st_t;

   typedef struct packed {
      gpc_tx_pins_t                    tx_pins;
      logic [SYNC_STAGES-1:0]          col_sync;
      logic [SYNC_STAGES-1:0]          crs_sync;
      logic [SYNC_STAGES-1:0]          rxc_sync;
      logic                            col_lvl;
      logic                            crs_lvl;
      logic                            rxc_lvl;
      gpc_rx_sample_t [SYNC_STAGES-1:0] rx_sync;
      gpc_rx_sample_t [RX_TAPS-1:0]    rx_tap;
      gpc_rx_phase_t                   phase;
      logic [3:0]                      lo_nib;
      logic                            lo_dv;
      gpc_byte_t                       rx_byte;
      logic                            rx_valid;
   } gpc_top_st_t;

endpackage

// ==== gpc_buf.sv ====
// Two-entry buffer between the user transmit stream and the pad registers.
// Assumes synchronous use on the system clock and a synchronised reset.
`timescale 1ns/1ns
`default_nettype none
module gpc_buf
   import gpc_pkg::*;
(
   input  wire logic      sys_clk_in,
   input  wire logic      rst_b_in,
   input  wire logic      ce_in,
   input  wire logic      in_valid_in,
   output logic           in_ready_out,
   input  wire gpc_byte_t in_data_in,
   output logic           out_valid_out,
   input  wire logic      out_ready_in,
   output gpc_byte_t      out_data_out
);

   gpc_buf_st_t st_r;
   gpc_buf_st_t st_nxt;
   logic        push;
   logic        pop;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   assign in_ready_out  = (st_r.cnt != BUF_FULL);
   assign out_valid_out = (st_r.cnt != BUF_EMPTY);
   assign out_data_out  = st_r.mem[st_r.rp];
   assign push          = ce_in && in_valid_in && in_ready_out;
   assign pop           = ce_in && out_valid_out && out_ready_in;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.mem[st_r.wp] = in_data_in;
         st_nxt.wp           = !st_r.wp;
      end
      if (pop)
      begin
         st_nxt.rp = !st_r.rp;
      end
      if (push && !pop)
      begin
         st_nxt.cnt = st_r.cnt + BUF_ONE;
      end
      else if (pop && !push)
      begin
         st_nxt.cnt = st_r.cnt - BUF_ONE;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_buf_no_overfill: assert property (st_r.cnt <= BUF_FULL)
      else $error("buffer count above two");
   a_buf_holds_word: assert property (
      out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out))
      else $error("stalled word lost or changed");

endmodule
`default_nettype wire

// ==== gpc_phy_model.sv ====
// External PHY model: receive clock, receive pins and sense levels.
// Assumes the bench calls its tasks from the system clock's rising edge.
`timescale 1ns/1ns
`default_nettype none
module gpc_phy_model
   import gpc_pkg::*;
(
   input  wire logic      sys_clk_in,
   output logic           rx_clk_out,
   output gpc_rx_sample_t rx_out,
   output logic           col_out,
   output logic           crs_out
);
   // Half period long enough for the deepest tap plus the sync stages
   localparam int HALF = 12;

   initial
   begin
      rx_clk_out = 1'h0;
      rx_out     = '0;
      col_out    = 1'h0;
      crs_out    = 1'h0;
   end

   // -------------------------------------
   // Receive byte; clock stands low outside it
   // -------------------------------------
   task automatic send(input logic [7:0] b, input logic e, input logic rg);
   begin
      @(posedge sys_clk_in);
      if (rg)
         rx_out <= {~b[3:0], b[3:0], 1'h1, 1'h1};
      else
         rx_out <= {b, 1'h1, e};
      repeat (HALF) @(posedge sys_clk_in);
      rx_clk_out <= 1'h1;
      if (rg)
         rx_out <= {~b[7:4], b[7:4], ~e, 1'h0};
      repeat (HALF) @(posedge sys_clk_in);
      rx_clk_out <= 1'h0;
      // Released lines show the inverse so stale data cannot pass
      rx_out     <= {~b, 1'h0, ~e};
      repeat (HALF) @(posedge sys_clk_in);
   end
   endtask

   task automatic sense(input logic c, input logic s);
   begin
      @(posedge sys_clk_in);
      col_out <= c;
      crs_out <= s;
   end
   endtask
endmodule
`default_nettype wire

// ==== test_gpc_phy_if.sv ====
// Self-checking bench for the gigabit PHY-side interface block.
// Assumes the package, the design and the PHY model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_gpc_phy_if
   import gpc_pkg::*;
;
   logic                sys_clk_in;
   logic                rst_b_in;
   logic                ce_in;
   logic                cfg_rgmii_in;
   logic                cfg_out_delay_in;
   logic                cfg_half_duplex_in;
   logic [RX_TAP_W-1:0] rx_tap_sel_in;
   gpc_byte_t           tx_byte_in;
   logic                tx_valid_in;
   logic                tx_ready_out;
   gpc_tx_pins_t        tx_pins_out;
   logic                phy_col_in;
   logic                phy_crs_in;
   logic                phy_rx_clk_in;
   gpc_rx_sample_t      phy_rx_in;
   gpc_byte_t           rx_byte_out;
   logic                rx_valid_out;
   logic                col_out;
   logic                crs_out;
   logic [1:0]          cq;
   logic                mon_on;
   int                  mismatches = 0;
   int                  samples_checked = 0;
   int                  cycles = 0;
   gpc_byte_t           tx_q[$];
   gpc_byte_t           rx_q[$];

   gpc_phy_if gpc_phy_if_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
      .cfg_rgmii_in(cfg_rgmii_in), .cfg_out_delay_in(cfg_out_delay_in),
      .cfg_half_duplex_in(cfg_half_duplex_in), .rx_tap_sel_in(rx_tap_sel_in),
      .tx_byte_in(tx_byte_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
      .tx_pins_out(tx_pins_out), .phy_col_in(phy_col_in), .phy_crs_in(phy_crs_in),
      .phy_rx_clk_in(phy_rx_clk_in), .phy_rx_in(phy_rx_in), .rx_byte_out(rx_byte_out),
      .rx_valid_out(rx_valid_out), .col_out(col_out), .crs_out(crs_out));

   gpc_phy_model gpc_phy_model_inst (.sys_clk_in(sys_clk_in), .rx_clk_out(phy_rx_clk_in),
      .rx_out(phy_rx_in), .col_out(phy_col_in), .crs_out(phy_crs_in));

   initial
   begin
      sys_clk_in = 1'h0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // -------------------------------------
   // Checking
   // -------------------------------------
   task automatic chk_bit(input logic got, input logic exp, input string what);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %b", $time, what, got);
      end
   end
   endtask

   task automatic chk_byte(input gpc_byte_t got, input gpc_byte_t exp, input string what);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   end
   endtask

   task automatic test_done;
   begin
      $display("Mismatches %0d checks %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask

   // Pins load from the mode of the previous cycle, so track it delayed
   always @(posedge sys_clk_in)
   begin
      cq <= {cfg_rgmii_in, cfg_out_delay_in};
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         $display("MISMATCH %0t run too long", $time);
         test_done;
      end
   end

   always @(negedge sys_clk_in)
   begin
      if (mon_on)
      begin
         chk_bit(tx_pins_out.clk_rise, cq[1], "fwd clk rise");
         chk_bit(tx_pins_out.clk_fall, ~cq[1], "fwd clk fall");
         if (cq[1])
         begin
            chk_bit(tx_pins_out.clk_delay, cq[0], "delayed clk");
            chk_bit(tx_pins_out.clk_quad, ~cq[0], "quad clk");
         end
         if (tx_pins_out.en_rise === 1'h1)
         begin
            chk_bit(tx_q.size() != 0, 1'h1, "tx byte expected");
            if (cq[1])
               chk_byte({tx_pins_out.d_rise[7:4], tx_pins_out.d_fall[7:4], tx_pins_out.er_rise},
                  9'h000, "unused lines");
            else
               chk_byte({tx_pins_out.d_fall, tx_pins_out.er_fall},
                  {tx_pins_out.d_rise, tx_pins_out.er_rise}, "gmii halves");
            if (tx_q.size() != 0)
               chk_byte(cq[1] ? {tx_pins_out.d_fall[3:0], tx_pins_out.d_rise[3:0],
                  ~tx_pins_out.en_fall} : {tx_pins_out.d_rise, tx_pins_out.er_rise},
                  tx_q.pop_front(), "tx byte");
         end
         if (rx_valid_out === 1'h1)
         begin
            chk_bit(rx_q.size() != 0, 1'h1, "rx byte expected");
            if (rx_q.size() != 0)
               chk_byte(rx_byte_out, rx_q.pop_front(), "rx byte");
         end
      end
   end

   // -------------------------------------
   // Scenarios
   // -------------------------------------
   task automatic tx_send(input gpc_byte_t b);
      logic ok;
   begin
      tx_byte_in  <= b;
      tx_valid_in <= 1'h1;
      do
      begin
         @(negedge sys_clk_in);
         ok = tx_ready_out;
         @(posedge sys_clk_in);
      end while (ok !== 1'h1);
      tx_q.push_back(b);
   end
   endtask

   task automatic t_tx_modes;
   begin
      for (int m = 0; m < 3; m++)
      begin
         cfg_rgmii_in     <= m != 0;
         cfg_out_delay_in <= m == 1;
         repeat (2) @(posedge sys_clk_in);
         tx_send(9'h000);
         tx_send(9'h1ff);
         tx_send(9'h14b);
         tx_valid_in <= 1'h0;
         repeat (6) @(posedge sys_clk_in);
         chk_bit(tx_q.size() == 0, 1'h1, "tx delivered");
      end
   end
   endtask

   task automatic t_tx_stall;
   begin
      cfg_half_duplex_in <= 1'h1;
      gpc_phy_model_inst.sense(1'h0, 1'h1);
      repeat (8) @(posedge sys_clk_in);
      tx_send(9'h12e);
      tx_send(9'h0c3);
      tx_byte_in <= 9'h1f0;
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk_bit(tx_ready_out, 1'h0, "full refused");
      chk_bit(tx_q.size() == 2, 1'h1, "held on carrier");
      gpc_phy_model_inst.sense(1'h0, 1'h0);
      tx_send(9'h1f0);
      tx_valid_in        <= 1'h0;
      cfg_half_duplex_in <= 1'h0;
      repeat (10) @(posedge sys_clk_in);
      chk_bit(tx_q.size() == 0, 1'h1, "drained");
   end
   endtask

   task automatic t_sense;
   begin
      for (int i = 0; i < 2; i++)
      begin
         gpc_phy_model_inst.sense(i == 0, i == 1);
         repeat (2) @(posedge sys_clk_in);
         @(negedge sys_clk_in);
         chk_bit(i == 0 ? col_out : crs_out, 1'h0, "sense early");
         repeat (3) @(posedge sys_clk_in);
         @(negedge sys_clk_in);
         chk_bit(i == 0 ? col_out : crs_out, 1'h1, "sense level");
         gpc_phy_model_inst.sense(1'h0, 1'h0);
         repeat (6) @(posedge sys_clk_in);
      end
   end
   endtask

   // Enable low must freeze the sense synchronisers as well
   task automatic t_ce_hold;
   begin
      ce_in <= 1'h0;
      gpc_phy_model_inst.sense(1'h1, 1'h0);
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk_bit(col_out, 1'h0, "frozen while disabled");
      @(posedge sys_clk_in);
      ce_in <= 1'h1;
      repeat (5) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk_bit(col_out, 1'h1, "resumed after enable");
      gpc_phy_model_inst.sense(1'h0, 1'h0);
      repeat (6) @(posedge sys_clk_in);
   end
   endtask

   task automatic t_rx;
      gpc_byte_t b;
   begin
      for (int m = 0; m < 2; m++)
         for (int t = 0; t < 8; t++)
         begin
            cfg_rgmii_in  <= m[0];
            rx_tap_sel_in <= t[2:0];
            b = {t[7:0] * 8'h25 + 8'h3c, t[0] ^ m[0]};
            rx_q.push_back(b);
            gpc_phy_model_inst.send(b.data, b.err, m[0]);
            repeat (4) @(posedge sys_clk_in);
            chk_bit(rx_q.size() == 0, 1'h1, "rx delivered");
         end
   end
   endtask

   initial
   begin
      rst_b_in           = 1'h0;
      ce_in              = 1'h1;
      cfg_rgmii_in       = 1'h0;
      cfg_out_delay_in   = 1'h0;
      cfg_half_duplex_in = 1'h0;
      rx_tap_sel_in      = '0;
      tx_byte_in         = '0;
      tx_valid_in        = 1'h0;
      mon_on             = 1'h0;
      repeat (8) @(posedge sys_clk_in);
      rst_b_in <= 1'h1;
      repeat (4) @(posedge sys_clk_in);
      mon_on <= 1'h1;
      t_tx_modes;
      t_tx_stall;
      t_sense;
      t_ce_hold;
      t_rx;
      test_done;
   end
endmodule
`default_nettype wire
